// ===== rtl/wrw_pkg.sv
package wrw_pkg;
  // Register map; the control register sits at byte offset 0x0c.
  localparam logic [11:0] WRW_CTRL_OFFSET = 12'h00c;
  localparam logic [7:0] WRW_CTRL_RESET = 8'h7f;
  localparam int WRW_ACT_BIT = 7;
  localparam int WRW_TOP_BIT = 6;
  localparam int WRW_COUNT_W = 7;
  // Step length in machine cycles and wake-up delay in CPU clocks.
  localparam int WRW_STEP_CYCLES = 49152;
  localparam int WRW_WAKE_CYCLES = 4096;
  // Reset pulse width: 500 ns at 10 ns per clock.
  localparam int WRW_PULSE_NS = 500;
  localparam int WRW_CLK_NS = 10;
  localparam int WRW_PULSE_CYCLES = (WRW_PULSE_NS + WRW_CLK_NS - 1) / WRW_CLK_NS;
  localparam logic [1:0] WRW_HTRANS_NONSEQ = 2'b10;
  typedef enum logic [1:0] {WRW_RUN, WRW_HALTED, WRW_WAKING} wrw_state_e;
endpackage : wrw_pkg

// ===== rtl/wrw_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module wrw_prescaler #(
  parameter int LENGTH = 49152
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic restart,
  input wire logic run,
  output logic tick
);
  localparam int W = $clog2(LENGTH);
  localparam logic [W-1:0] LAST = W'(LENGTH - 1);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  wire at_last = (cnt_reg == LAST);

  assign cnt_next = restart ? '0 : (!run ? cnt_reg : (at_last ? '0 : cnt_reg + W'(1)));
  assign tick = run && !restart && at_last;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_next;
  end
endmodule : wrw_prescaler
`default_nettype wire

// ===== rtl/wrw_watchdog.sv
// Notes on behaviour
// - Count field decrements once per 49,152 machine cycles; 64 programmable steps.
// - Enabled and count rolling 40h to 3Fh starts a 500 ns low reset pulse.
// - After any reset the watchdog is disabled, activation bit clear.
// - Activation bit set only by software; writing zero ignored; sticky until reset.
// - Write setting activation with top count bit clear resets immediately.
// - While halted the count freezes and no watchdog reset is produced.
// - After external-interrupt wake-up, counting resumes only after 4096 clocks.
// - Control register resets to 7Fh.
// - Bit 7 activation, bits 6:0 count; reads return the current count.
`timescale 1ns/1ps
`default_nettype none
module wrw_watchdog
  import wrw_pkg::*;
#(
  parameter int STEP_CYCLES = WRW_STEP_CYCLES,
  parameter int WAKE_CYCLES = WRW_WAKE_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic halt_req,
  input wire logic ext_wake,
  output logic reset_n_out
);
  localparam int WW = $clog2(WAKE_CYCLES + 1);
  localparam int PW = $clog2(WRW_PULSE_CYCLES + 1);
  localparam logic [WW-1:0] WAKE_LAST = WW'(WAKE_CYCLES - 1);
  localparam logic [PW-1:0] PULSE_LEN = PW'(WRW_PULSE_CYCLES);
  localparam logic [WRW_COUNT_W-1:0] ROLL_FROM = 7'h40;

  // The block is one control register, a step prescaler, a seven-bit down counter and a
  // reset pulse stretcher. The halt sequencer only gates the prescaler; it never touches
  // the count, so software always reads back what the hardware will act on.

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: one-cycle address phase captured, zero-wait data phase.
  logic wr_pend_reg;
  logic [31:0] hrdata_reg;
  logic act_reg;
  logic [WRW_COUNT_W-1:0] count_reg;
  wire addr_take = hsel && hready && (htrans == WRW_HTRANS_NONSEQ);
  wire addr_hit = (haddr[11:0] == WRW_CTRL_OFFSET);
  wire ctrl_wr = wr_pend_reg;
  // Only the low byte carries the register; the upper write lanes are ignored.
  wire [7:0] wdata = hwdata[7:0];
  wire [31:0] rd_word = {24'h000000, act_reg, count_reg};
  // Reads sample the live count so software sees the decremented value.
  // The value is taken at the address phase, so a decrement that lands in the data
  // phase shows up only on the next read; software polling the count must allow for it.
  wire [31:0] rdata_next = (addr_take && !hwrite && addr_hit) ? rd_word : 32'h00000000;

  // The write strobe is carried into the data phase, where hwdata is valid.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wr_pend_reg <= 1'b0;
    else
      wr_pend_reg <= addr_take && hwrite && addr_hit;
  end

  // Read data come from a register and fall back to zero after every other cycle.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_reg <= 32'h00000000;
    else
      hrdata_reg <= rdata_next;
  end

  // The slave never stalls and never errors, so the handshake outputs are fixed.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Halt and wake sequencing.
  // While halted the whole chip clock would be stopped; here the clock keeps running and
  // the sequencer simply holds the prescaler still. A wake request only counts in the
  // halted state, so a stray wake while running cannot shorten a step.
  wrw_state_e state_reg;
  wrw_state_e state_next;
  logic [WW-1:0] wake_reg;
  logic [WW-1:0] wake_next;
  wire wake_done = (wake_reg == WAKE_LAST);

  always_comb
  begin
    state_next = state_reg;
    wake_next = '0;
    case (state_reg)
      WRW_RUN:
        if (halt_req)
          state_next = WRW_HALTED;
      WRW_HALTED:
        if (ext_wake)
          state_next = WRW_WAKING;
      WRW_WAKING:
      begin
        wake_next = wake_reg + WW'(1);
        if (wake_done)
          state_next = WRW_RUN;
      end
      default:
        state_next = WRW_RUN;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_reg <= WRW_RUN;
    else
      state_reg <= state_next;
  end

  // The wake counter is cleared outside the waking state, so every wake-up waits in full.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wake_reg <= '0;
    else
      wake_reg <= wake_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter, activation and reset pulse.
  wire running = (state_reg == WRW_RUN);
  logic step_tick;

  // The prescaler keeps its partial count across a halt, so the first step after a
  // wake-up may be shorter than a full one; refreshing before halt avoids the surprise.

  wrw_prescaler #(
    .LENGTH(STEP_CYCLES)
  ) u_prescaler (
    .hclk(hclk),
    .hresetn(hresetn),
    .restart(ctrl_wr),
    .run(running),
    .tick(step_tick)
  );

  // Activation can only be added by a write; nothing but the block reset removes it.
  wire act_next = act_reg | (ctrl_wr & wdata[WRW_ACT_BIT]);
  // A write wins over a decrement in the same cycle, so a refresh is never lost.
  wire [WRW_COUNT_W-1:0] count_next = ctrl_wr ? wdata[WRW_COUNT_W-1:0] :
    (step_tick ? count_reg - 7'h01 : count_reg);
  wire roll_fire = step_tick && !ctrl_wr && act_reg && (count_reg == ROLL_FROM);
  // A write setting the activation bit with the top count bit clear acts as a software reset.
  wire soft_fire = ctrl_wr && wdata[WRW_ACT_BIT] && !wdata[WRW_TOP_BIT];
  logic [PW-1:0] pulse_reg;
  logic rst_out_reg;
  // A second fire during a running pulse is dropped: the system is already being reset,
  // and restarting the stretcher would only make the pulse length depend on software.
  wire fire = (roll_fire || soft_fire) && pulse_reg == '0;
  wire [PW-1:0] pulse_next = fire ? PULSE_LEN : (pulse_reg != '0 ? pulse_reg - PW'(1) : pulse_reg);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      act_reg <= WRW_CTRL_RESET[WRW_ACT_BIT];
    else
      act_reg <= act_next;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      count_reg <= WRW_CTRL_RESET[WRW_COUNT_W-1:0];
    else
      count_reg <= count_next;
  end

  // The stretcher counts the remaining low cycles of the outgoing reset pulse.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pulse_reg <= '0;
    else
      pulse_reg <= pulse_next;
  end

  // The pin level is registered from the next stretcher value, so it goes low in the
  // same cycle as the stretcher is loaded and has no glitch from the decode logic.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rst_out_reg <= 1'b1;
    else
      rst_out_reg <= (pulse_next == '0);
  end

  // Only a reset request leaves this block; there is no interrupt.
  assign reset_n_out = rst_out_reg;
endmodule : wrw_watchdog
`default_nettype wire

// ===== testbench/wrw_rst_model.sv
`timescale 1ns/1ps
`default_nettype none
// Stands in for the system reset logic; it records how long each low pulse lasted.
module wrw_rst_model (
  input wire logic hclk,
  input wire logic reset_n_out,
  output int width
);
  int cnt = 0;
  always @(posedge hclk)
  begin
    cnt <= reset_n_out ? 0 : cnt + 1;
    if (reset_n_out && cnt != 0) width <= cnt;
  end
endmodule : wrw_rst_model
`default_nettype wire

// ===== testbench/wrw_watchdog_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module wrw_watchdog_asserts import wrw_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic reset_n_out
);
  logic req, rd_q, act_q;
  assign req = hsel && hready && htrans == WRW_HTRANS_NONSEQ && haddr[11:0] == WRW_CTRL_OFFSET;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) {rd_q, act_q} <= 2'b00;
    else {rd_q, act_q} <= {req && !hwrite, act_q || (rd_q && hrdata[7])};
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_bus; hreadyout && !hresp; endproperty
  a_bus: assert property (p_bus) else $error("bus not ready or not okay");
  property p_pulse; $fell(reset_n_out) |-> ##49 !reset_n_out ##1 reset_n_out; endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse width wrong");
  property p_swrst; req && hwrite ##1 hwdata[7:6] == 2'b10 |=> !reset_n_out; endproperty
  a_swrst: assert property (p_swrst) else $error("software reset missing");
  property p_rel; $rose(hresetn) |-> reset_n_out && hrdata == 32'h0; endproperty
  a_rel: assert property (p_rel) else $error("outputs wrong after reset");
  property p_idle; !(req && !hwrite) |=> hrdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data without read");
  property p_hi; rd_q |-> hrdata[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_sticky; rd_q && act_q |-> hrdata[7]; endproperty
  a_sticky: assert property (p_sticky) else $error("activation bit lost");
  property p_load;
    req && hwrite ##1 hwdata[7:6] == 2'b11 ##1 req && !hwrite |=> hrdata[7:0] == $past(hwdata[7:0], 2);
  endproperty
  a_load: assert property (p_load) else $error("written count not loaded");
  c_fire: cover property ($fell(reset_n_out));
  c_act: cover property (rd_q && act_q);
  c_wr: cover property (req && hwrite);
endmodule : wrw_watchdog_asserts
bind wrw_watchdog wrw_watchdog_asserts u_chk (.*);
`default_nettype wire

// ===== testbench/tb_windowed_reset_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
module tb_windowed_reset_watchdog import wrw_pkg::*;;
  localparam int STEP = 16;
  localparam logic [11:0] C = WRW_CTRL_OFFSET;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, halt_req = 0, ext_wake = 0, hready;
  logic hreadyout, hresp, reset_n_out;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  int fails = 0, comparisons = 0, width;
  assign hready = hreadyout;
  always #5 hclk = ~hclk;
  wrw_watchdog #(.STEP_CYCLES(STEP), .WAKE_CYCLES(8)) DUT (.*);
  wrw_rst_model u_rst (.hclk(hclk), .reset_n_out(reset_n_out), .width(width));
  ////////////////////////////////////////////////////////////////////////////////
  task print_verdict;
    if (fails == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  task chk(string n, logic [31:0] s, logic [31:0] e);
    comparisons++;
    if (s !== e) begin fails++; $display("Error %s exp %h seen %h", n, e, s); end
  endtask : chk
  task cyc(int n);
    repeat (n) @(posedge hclk);
  endtask : cyc
  // Both phases wait on hready; the slave is zero-wait today but may not stay so.
  task ahb(logic w, logic [11:0] a, logic [31:0] d);
    int i;
    hsel <= 1; htrans <= WRW_HTRANS_NONSEQ; haddr <= {20'h0, a}; hwrite <= w;
    i = 0;
    do begin @(posedge hclk); i++; end while (hready !== 1'b1 && i < 20);
    hsel <= 0; htrans <= 2'b00; hwdata <= d;
    do begin @(posedge hclk); i++; end while (hready !== 1'b1 && i < 40);
    rd = hrdata;
    if (i >= 20) begin fails++; print_verdict; end
  endtask : ahb
  task t_basic;
    ahb(0, C, 0); chk("ctrl", rd, 32'h7f);
    ahb(1, 12'h010, 32'hff); ahb(0, 12'h010, 0); chk("unmapped", rd, 0);
    ahb(1, C, 32'h40); ahb(0, C, 0); chk("inactive", rd, 32'h40);
    cyc(STEP + 4); chk("no fire", reset_n_out, 1);
  endtask : t_basic
  task t_timeout;
    int i;
    ahb(1, C, 32'hc1);
    ahb(0, C, 0); chk("refresh", rd, 32'hc1);
    cyc(STEP); ahb(0, C, 0); chk("step", rd, 32'hc0);
    for (i = 0; reset_n_out !== 1'b0 && i < 100; i++) @(posedge hclk);
    chk("fire", i < 100, 1);
    ahb(0, C, 0); chk("rolled", rd, 32'hbf);
    cyc(60); chk("width", width, 50);
    ahb(1, C, 32'h7f); ahb(0, C, 0); chk("sticky", rd, 32'hff);
  endtask : t_timeout
  task t_halt;
    ahb(1, C, 32'hc5);
    halt_req <= 1; cyc(1); halt_req <= 0; cyc(100);
    ahb(0, C, 0); chk("frozen", rd, 32'hc5);
    ext_wake <= 1; cyc(1); ext_wake <= 0;
    ahb(0, C, 0); chk("waking", rd, 32'hc5);
    cyc(24); ahb(0, C, 0); chk("resumed", rd, 32'hc4);
  endtask : t_halt
  task t_rst;
    hresetn <= 0; cyc(2); hresetn <= 1; cyc(1);
    chk("rst pin", reset_n_out, 1);
    ahb(0, C, 0); chk("after reset", rd, 32'h7f);
  endtask : t_rst
  task t_sw;
    ahb(1, C, 32'h80); cyc(1); chk("swreset", reset_n_out, 0);
  endtask : t_sw
  initial
  begin
    cyc(10); hresetn <= 1; cyc(1);
    t_basic; t_timeout; t_halt; t_rst; t_sw;
    print_verdict;
  end
endmodule : tb_windowed_reset_watchdog
`default_nettype wire
